// file: avs_pkg.sv
/*
 * avs_pkg: shared constants and types of the audio/video switch control block.
 * Holds register indices, field positions, reset values, selector encodings and
 * the packed structs that carry routing, audio and function pin controls.
 * Assumes every user compiles this package first and refers to it by avs_pkg::name.
 */
package avs_pkg;

	// register indices, loaded in this order from index zero upward
	localparam int unsigned AVS_NUM_REGS = 5;
	localparam logic [2:0] AVS_REG_VOLUME = 3'h0;
	localparam logic [2:0] AVS_REG_SOURCE = 3'h1;
	localparam logic [2:0] AVS_REG_VIDEO = 3'h2;
	localparam logic [2:0] AVS_REG_MODE = 3'h3;
	localparam logic [2:0] AVS_REG_BYPASS = 3'h4;

	// reset values: both mutes on, aux and tv video muted, stereo, volume active
	localparam logic [7:0] AVS_RST_VOLUME = 8'hC0;
	localparam logic [7:0] AVS_RST_SOURCE = 8'h3F;
	localparam logic [7:0] AVS_RST_VIDEO = 8'h00;
	localparam logic [7:0] AVS_RST_MODE = 8'h00;
	localparam logic [7:0] AVS_RST_BYPASS = 8'h00;

	// field positions
	localparam int unsigned AVS_ATTEN_LSB = 0;
	localparam int unsigned AVS_TV_MUTE_BIT = 6;
	localparam int unsigned AVS_AUX_MUTE_BIT = 7;
	localparam int unsigned AVS_TV_SRC_LSB = 0;
	localparam int unsigned AVS_AUX_SRC_LSB = 3;
	localparam int unsigned AVS_FNC_LEVEL_LSB = 0;
	localparam int unsigned AVS_FNC_DIR_LSB = 2;
	localparam int unsigned AVS_DAC_GAIN_LSB = 2;
	localparam int unsigned AVS_STEREO_LSB = 4;
	localparam int unsigned AVS_SCART_BYP_BIT = 0;
	localparam int unsigned AVS_LINE_BYP_BIT = 1;
	localparam int unsigned AVS_VOL_GAIN_BIT = 2;
	localparam int unsigned AVS_LINE_TV_BIT = 3;

	// auxiliary source codes
	localparam logic [2:0] AVS_AUX_ENC_BLUE = 3'h0;
	localparam logic [2:0] AVS_AUX_ENC_COMPOSITE = 3'h1;
	localparam logic [2:0] AVS_AUX_TV_COMPOSITE = 3'h2;
	localparam logic [2:0] AVS_AUX_SVHS1 = 3'h3;
	localparam logic [2:0] AVS_AUX_SVHS2 = 3'h4;
	localparam logic [2:0] AVS_AUX_SVHS3 = 3'h5;
	localparam logic [2:0] AVS_AUX_SVHS4 = 3'h6;
	localparam logic [2:0] AVS_AUX_MUTE = 3'h7;

	// function pin direction codes and levels
	localparam logic [1:0] AVS_DIR_BOTH_OUT = 2'h0;
	localparam logic [1:0] AVS_DIR_AUX_OUT = 2'h1;
	localparam logic [1:0] AVS_DIR_TV_OUT = 2'h2;
	localparam logic [1:0] AVS_DIR_PASS = 2'h3;
	localparam logic [1:0] AVS_LVL_0V = 2'h0;
	localparam logic [1:0] AVS_LVL_6V = 2'h1;
	localparam logic [1:0] AVS_LVL_11V = 2'h2;

	// video source selected onto an auxiliary output
	typedef enum logic [3:0] {VS_ZERO, VS_ENC_BLUE, VS_ENC_COMPOSITE, VS_TV_COMPOSITE, VS_ENC_CHROMA,
		VS_ENC_LUMA, VS_ENC_GREEN, VS_ENC_RED, VS_SECOND_ENC_CHROMA, VS_SECOND_ENC_LUMA} avs_vid_src_t;
	// audio input pair selected
	typedef enum logic [1:0] {AS_DAC, AS_AUX, AS_TV_SCART} avs_aud_src_t;

	typedef struct packed {
		avs_vid_src_t chroma;
		avs_vid_src_t composite;
		avs_aud_src_t audio;
	} avs_aux_route_t;

	typedef struct packed {
		avs_aud_src_t tv_source;
		logic [1:0] stereo_mode;
		logic vol_gain_6db;
		logic [5:0] atten_db;
		logic [1:0] dac_gain;
		logic scart_bypass;
		logic line_bypass;
		logic line_from_tv_scart;
		logic rf_mono_bypass;
		logic tv_mute;
		logic aux_mute;
	} avs_audio_t;

	typedef struct packed {
		logic oe;
		logic [1:0] level;
	} avs_fnc_pin_t;

	typedef struct packed {
		logic [2:0] idx;
		logic [7:0] data;
	} avs_link_byte_t;

endpackage : avs_pkg

// file: avs_ctrl.sv
/*
 * avs_ctrl: control register bank of the audio/video switch.
 * A serial link engine on its own clock hands over written bytes in order;
 * this block stores them in the five write registers and decodes the routing,
 * audio and function pin controls, and builds the read status byte.
 * Assumes the link engine runs on link_clk_in and marks transfer starts.
 */
//
// Summary of operation
// - aux field 000/001/010 picks blue, composite, tv
// - svhs formats 1..3 use encoder pins, dac audio
// - format 4 uses second encoder, tv scart audio
// - aux field 110 selects format four
// - aux field resets to 111, outputs zeroed
// - video bits 3:2 set function pin directions
// - pass-through forwards one pin to the other
// - input pin level reported in status low bits
// - output level from video bits 1:0
// - both outputs share one level
// - disable output on short at 6 or 11 V, external drive at 0 V
// - tv audio source follows tv source bits
// - mode bits 5:4 pick stereo/mono, reset stereo
// - bypass bit 2 picks 0 or 6 dB
// - volume low six bits attenuate 0..-63 dB
// - mode bits 3:2 set dac input gain
// - bypass bit 0 bypasses volume on scart
// - bypass bit 1 bypasses volume on line
// - bypass bit 3 feeds line from scart inputs
// - rf mono follows scart volume choice
// - volume bit 6 mutes tv audio, reset on
`timescale 1ns/100ps
module avs_ctrl #(
	parameter logic [3:0] DEVICE_ID = 4'hA // arbitrary identity value
) (
	// system clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// link side, on the link clock
	input wire logic link_clk_in,
	input wire logic xfer_start_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_data_in,
	output logic link_ready_out,
	// function pins: sensed comparator code, drive level, enable
	input wire logic [1:0] aux_fnc_sense_in,
	input wire logic [1:0] tv_function_pin_sense_in,
	input wire logic [1:0] fnc_gnd_short_in,
	input wire logic [1:0] fnc_ext_drive_in,
	output avs_pkg::avs_fnc_pin_t aux_fnc_out,
	output avs_pkg::avs_fnc_pin_t tv_function_pin_out,
	// decoded controls and status
	output avs_pkg::avs_aux_route_t aux_route_out,
	output avs_pkg::avs_audio_t audio_out,
	output logic [7:0] status_out
);

	// link domain state
	typedef struct packed {
		logic [2:0] idx; // next register index of this transfer
		avs_pkg::avs_link_byte_t hold; // byte waiting for the system side
		logic req_tgl; // toggles once per handed-over byte
		logic ack_s1; // acknowledge synchroniser, first stage
		logic ack_s2; // acknowledge synchroniser, second stage
		logic busy; // hold is not yet taken
		logic ready; // drives link_ready_out
	} avs_link_t;

	// system domain state
	typedef struct packed {
		logic [avs_pkg::AVS_NUM_REGS-1:0][7:0] regs; // write registers
		logic req_s1; // request synchroniser, first stage
		logic req_s2; // request synchroniser, second stage
		logic req_s3; // edge detection delay
		logic ack_tgl; // returned to the link side
		logic [1:0] aux_sense_s1;
		logic [1:0] aux_sense_s2;
		logic [1:0] tv_sense_s1;
		logic [1:0] tv_sense_s2;
		logic [1:0] gnd_s1;
		logic [1:0] gnd_s2;
		logic [1:0] ext_s1;
		logic [1:0] ext_s2;
		avs_pkg::avs_aux_route_t aux_route;
		avs_pkg::avs_audio_t audio;
		avs_pkg::avs_fnc_pin_t aux_pin;
		avs_pkg::avs_fnc_pin_t tv_pin;
		logic [7:0] status;
	} avs_sys_t;

	// reset image matches the decode of the reset register values, except pin enables and status, which reset to zero
	localparam avs_sys_t SYS_RST = '{
		regs: {avs_pkg::AVS_RST_BYPASS, avs_pkg::AVS_RST_MODE, avs_pkg::AVS_RST_VIDEO,
			avs_pkg::AVS_RST_SOURCE, avs_pkg::AVS_RST_VOLUME},
		audio: '{tv_source: avs_pkg::AS_AUX, tv_mute: 1'b1, aux_mute: 1'b1, default: '0},
		default: '0
	};

	avs_link_t l; // link registers
	avs_link_t next_l; // link next state
	avs_sys_t s; // system registers
	avs_sys_t next_s; // system next state

	// auxiliary routing per source code
	function automatic avs_pkg::avs_aux_route_t aux_decode(input logic [2:0] code);
		avs_pkg::avs_aux_route_t r;
		r = '{chroma: avs_pkg::VS_ZERO, composite: avs_pkg::VS_ZERO, audio: avs_pkg::AS_DAC};
		case (code)
			avs_pkg::AVS_AUX_ENC_BLUE: r.composite = avs_pkg::VS_ENC_BLUE;
			avs_pkg::AVS_AUX_ENC_COMPOSITE: r.composite = avs_pkg::VS_ENC_COMPOSITE;
			avs_pkg::AVS_AUX_TV_COMPOSITE:
			begin
				r.composite = avs_pkg::VS_TV_COMPOSITE;
				r.audio = avs_pkg::AS_TV_SCART;
			end
			avs_pkg::AVS_AUX_SVHS1:
			begin
				r.chroma = avs_pkg::VS_ENC_CHROMA;
				r.composite = avs_pkg::VS_ENC_LUMA;
			end
			avs_pkg::AVS_AUX_SVHS2:
			begin
				r.chroma = avs_pkg::VS_ENC_BLUE;
				r.composite = avs_pkg::VS_ENC_GREEN;
			end
			avs_pkg::AVS_AUX_SVHS3:
			begin
				r.chroma = avs_pkg::VS_ENC_RED;
				r.composite = avs_pkg::VS_ENC_GREEN;
			end
			avs_pkg::AVS_AUX_SVHS4:
			begin
				r.chroma = avs_pkg::VS_SECOND_ENC_CHROMA;
				r.composite = avs_pkg::VS_SECOND_ENC_LUMA;
				r.audio = avs_pkg::AS_TV_SCART;
			end
			default: r.audio = avs_pkg::AS_DAC;
		endcase
		return r;
	endfunction : aux_decode

	// map a level code onto a drive level; 11 drives the same as 10
	function automatic logic [1:0] lvl_map(input logic [1:0] code);
		// two top codes share 11 V
		return (code == avs_pkg::AVS_LVL_0V) ? avs_pkg::AVS_LVL_0V :
			(code == avs_pkg::AVS_LVL_6V) ? avs_pkg::AVS_LVL_6V : avs_pkg::AVS_LVL_11V;
	endfunction : lvl_map

	// link side: take bytes in order, hand each over by toggle handshake
	always_comb
	begin
		next_l = l;
		next_l.ack_s1 = s.ack_tgl;
		next_l.ack_s2 = l.ack_s1;
		// the handshake closes when the acknowledge toggle catches up
		if (l.busy && (l.ack_s2 == l.req_tgl))
		begin
			next_l.busy = 1'b0;
		end
		// a new transfer restarts loading at register zero
		if (xfer_start_in)
		begin
			next_l.idx = avs_pkg::AVS_REG_VOLUME;
		end
		if (byte_valid_in && l.ready)
		begin
			next_l.hold.idx = xfer_start_in ? avs_pkg::AVS_REG_VOLUME : l.idx;
			next_l.hold.data = byte_data_in;
			next_l.req_tgl = ~l.req_tgl;
			next_l.busy = 1'b1;
			// saturate so bytes past the last register land nowhere
			if (next_l.hold.idx < 3'(avs_pkg::AVS_NUM_REGS))
			begin
				next_l.idx = next_l.hold.idx + 3'h1;
			end
			else
			begin
				next_l.idx = next_l.hold.idx;
			end
		end
		// ready is registered, so a byte is refused while one is in flight
		next_l.ready = ~next_l.busy;
	end

	// link side registers
	always_ff @(posedge link_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			l <= '{ready: 1'b1, default: '0};
		end
		else
		begin
			l <= next_l;
		end
	end

	// system side: store bytes, sync pins, decode controls
	always_comb
	begin
		logic [1:0] dir;
		logic [1:0] lvl;
		logic [1:0] sensed;
		next_s = s;
		dir = '0;
		lvl = '0;
		sensed = '0;
		// two-stage synchronisers; only stage two is read
		next_s.req_s1 = l.req_tgl;
		next_s.req_s2 = s.req_s1;
		next_s.req_s3 = s.req_s2;
		next_s.aux_sense_s1 = aux_fnc_sense_in;
		next_s.aux_sense_s2 = s.aux_sense_s1;
		next_s.tv_sense_s1 = tv_function_pin_sense_in;
		next_s.tv_sense_s2 = s.tv_sense_s1;
		next_s.gnd_s1 = fnc_gnd_short_in;
		next_s.gnd_s2 = s.gnd_s1;
		next_s.ext_s1 = fnc_ext_drive_in;
		next_s.ext_s2 = s.ext_s1;
		// the held byte is stable for the whole handshake, so it is read direct
		if (s.req_s2 != s.req_s3)
		begin
			if (l.hold.idx < 3'(avs_pkg::AVS_NUM_REGS))
			begin
				next_s.regs[l.hold.idx] = l.hold.data;
			end
			next_s.ack_tgl = s.req_s2;
		end
		// decode from the next register image so outputs land with the store
		next_s.aux_route = aux_decode(next_s.regs[avs_pkg::AVS_REG_SOURCE][avs_pkg::AVS_AUX_SRC_LSB +: 3]);
		case (next_s.regs[avs_pkg::AVS_REG_SOURCE][avs_pkg::AVS_TV_SRC_LSB +: 3])
			3'h1, 3'h5, 3'h7: next_s.audio.tv_source = avs_pkg::AS_AUX;
			default: next_s.audio.tv_source = avs_pkg::AS_DAC;
		endcase
		next_s.audio.stereo_mode = next_s.regs[avs_pkg::AVS_REG_MODE][avs_pkg::AVS_STEREO_LSB +: 2];
		next_s.audio.vol_gain_6db = next_s.regs[avs_pkg::AVS_REG_BYPASS][avs_pkg::AVS_VOL_GAIN_BIT];
		next_s.audio.atten_db = next_s.regs[avs_pkg::AVS_REG_VOLUME][avs_pkg::AVS_ATTEN_LSB +: 6];
		next_s.audio.dac_gain = next_s.regs[avs_pkg::AVS_REG_MODE][avs_pkg::AVS_DAC_GAIN_LSB +: 2];
		next_s.audio.scart_bypass = next_s.regs[avs_pkg::AVS_REG_BYPASS][avs_pkg::AVS_SCART_BYP_BIT];
		next_s.audio.line_bypass = next_s.regs[avs_pkg::AVS_REG_BYPASS][avs_pkg::AVS_LINE_BYP_BIT];
		next_s.audio.line_from_tv_scart = next_s.regs[avs_pkg::AVS_REG_BYPASS][avs_pkg::AVS_LINE_TV_BIT];
		next_s.audio.rf_mono_bypass = next_s.audio.scart_bypass;
		next_s.audio.tv_mute = next_s.regs[avs_pkg::AVS_REG_VOLUME][avs_pkg::AVS_TV_MUTE_BIT];
		next_s.audio.aux_mute = next_s.regs[avs_pkg::AVS_REG_VOLUME][avs_pkg::AVS_AUX_MUTE_BIT];
		dir = next_s.regs[avs_pkg::AVS_REG_VIDEO][avs_pkg::AVS_FNC_DIR_LSB +: 2];
		lvl = lvl_map(next_s.regs[avs_pkg::AVS_REG_VIDEO][avs_pkg::AVS_FNC_LEVEL_LSB +: 2]);
		next_s.aux_pin = '{oe: 1'b0, level: avs_pkg::AVS_LVL_0V};
		next_s.tv_pin = '{oe: 1'b0, level: avs_pkg::AVS_LVL_0V};
		case (dir)
			avs_pkg::AVS_DIR_BOTH_OUT:
			begin
				next_s.aux_pin = '{oe: 1'b1, level: lvl};
				next_s.tv_pin = '{oe: 1'b1, level: lvl};
			end
			avs_pkg::AVS_DIR_AUX_OUT:
			begin
				next_s.aux_pin = '{oe: 1'b1, level: lvl};
				sensed = s.tv_sense_s2;
			end
			avs_pkg::AVS_DIR_TV_OUT:
			begin
				next_s.tv_pin = '{oe: 1'b1, level: lvl};
				sensed = s.aux_sense_s2;
			end
			default:
			begin
				// pass-through, aux wins when both sense a level
				if (s.aux_sense_s2 != avs_pkg::AVS_LVL_0V)
				begin
					next_s.tv_pin = '{oe: 1'b1, level: lvl_map(s.aux_sense_s2)};
					sensed = s.aux_sense_s2;
				end
				else if (s.tv_sense_s2 != avs_pkg::AVS_LVL_0V)
				begin
					next_s.aux_pin = '{oe: 1'b1, level: lvl_map(s.tv_sense_s2)};
					sensed = s.tv_sense_s2;
				end
				else
				begin
					sensed = avs_pkg::AVS_LVL_0V;
				end
			end
		endcase
		if ((next_s.aux_pin.level != avs_pkg::AVS_LVL_0V) ? s.gnd_s2[0] : s.ext_s2[0])
		begin
			next_s.aux_pin.oe = 1'b0;
		end
		if ((next_s.tv_pin.level != avs_pkg::AVS_LVL_0V) ? s.gnd_s2[1] : s.ext_s2[1])
		begin
			next_s.tv_pin.oe = 1'b0;
		end
		// status carries the sensed input level
		next_s.status = {DEVICE_ID, 2'h0, sensed};
	end

	// system side registers
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			s <= SYS_RST;
		end
		else
		begin
			s <= next_s;
		end
	end

	// outputs come straight from flip-flops
	assign link_ready_out = l.ready;
	assign aux_fnc_out = s.aux_pin;
	assign tv_function_pin_out = s.tv_pin;
	assign aux_route_out = s.aux_route;
	assign audio_out = s.audio;
	assign status_out = s.status;

	// encoder composite source follows field code 001
	property p_aux_comp;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(s.regs[1][5:3] == 3'h1) |-> (s.aux_route.composite == avs_pkg::VS_ENC_COMPOSITE
			&& s.aux_route.chroma == avs_pkg::VS_ZERO);
	endproperty
	a_aux_comp: assert property (p_aux_comp) else $error("aux composite source wrong");

	// svhs formats 1..3 use dac audio
	property p_aux_svhs;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(s.regs[1][5:3] inside {3'h3, 3'h4, 3'h5}) |-> (s.aux_route.audio == avs_pkg::AS_DAC
			&& s.aux_route.chroma != avs_pkg::VS_ZERO);
	endproperty
	a_aux_svhs: assert property (p_aux_svhs) else $error("aux svhs routing wrong");

	// fourth format routing
	property p_aux_enc4;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(s.regs[1][5:3] == 3'h6) |-> (s.aux_route.chroma == avs_pkg::VS_SECOND_ENC_CHROMA
			&& s.aux_route.audio == avs_pkg::AS_TV_SCART);
	endproperty
	a_aux_enc4: assert property (p_aux_enc4) else $error("aux format four wrong");

	// mute code zeroes the video
	property p_aux_mute;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(s.regs[1][5:3] == 3'h7) |-> (s.aux_route.composite == avs_pkg::VS_ZERO
			&& s.aux_route.audio == avs_pkg::AS_DAC);
	endproperty
	a_aux_mute: assert property (p_aux_mute) else $error("aux mute not applied");

	// tv pin input in code 01
	property p_fnc_dir;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(s.regs[2][3:2] == 2'h1) |-> (!s.tv_pin.oe && s.status[1:0] == $past(s.tv_sense_s2));
	endproperty
	a_fnc_dir: assert property (p_fnc_dir) else $error("function pin direction wrong");

	// both outputs carry one level
	property p_common_lvl;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(s.regs[2][3:2] == 2'h0) |-> (s.aux_pin.level == s.tv_pin.level);
	endproperty
	a_common_lvl: assert property (p_common_lvl) else $error("function levels differ");

	// grounded pin at 6 or 11 V is not driven
	property p_fault;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		($past(s.gnd_s2[0]) && s.aux_pin.level != 2'h0) |-> !s.aux_pin.oe;
	endproperty
	a_fault: assert property (p_fault) else $error("shorted function pin still driven");

	// mute bit reaches the audio controls
	property p_mute;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		s.audio.tv_mute == s.regs[0][6];
	endproperty
	a_mute: assert property (p_mute) else $error("tv mute mismatch");

	// a handed-over byte lands in its register on the next edge
	property p_store;
		@(posedge clk_sys_in) disable iff (!reset_n_in)
		(s.req_s2 != s.req_s3 && l.hold.idx == 3'h2) |=> (s.regs[2] == $past(l.hold.data));
	endproperty
	a_store: assert property (p_store) else $error("register store lost");

	// an accepted byte drops ready on the next link edge
	property p_link_busy;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		(byte_valid_in && l.ready) |=> (!l.ready ##1 !l.ready);
	endproperty
	a_link_busy: assert property (p_link_busy) else $error("link ready not dropped");

endmodule : avs_ctrl

// file: avs_host_model.sv
/*
 * avs_host_model: link-side writer standing in for the serial bus master.
 * Assumes the switch exposes a start, valid, data and ready byte handshake
 * on a link clock that this model makes.
 */
`timescale 1ns/100ps
module avs_host_model (
	// reset seen from the bench
	input wire logic reset_n_in,
	// link clock and byte handshake
	output logic link_clk_out,
	output logic xfer_start_out,
	output logic byte_valid_out,
	output logic [7:0] byte_data_out,
	input wire logic link_ready_in
);
	logic run; // high while a frame is open

	// idle values at time zero; data rests at a nonzero pattern
	initial
	begin
		run = 1'b0;
		link_clk_out = 1'b0;
		xfer_start_out = 1'b0;
		byte_valid_out = 1'b0;
		byte_data_out = 8'hA5;
	end

	// link clock, 160 ns; stands still low between frames, runs in reset
	always
	begin
		#80;
		if (run || !reset_n_in || link_clk_out)
			link_clk_out = ~link_clk_out;
	end

	// send n bytes from register zero upward in one transfer; drives change on falling edges
	task write_seq(input int n, input logic [7:0] d [5]);
		int w;
		run = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			// bounded wait for the device to be ready
			w = 0;
			do
			begin
				@(negedge link_clk_out);
				w++;
			end
			while (link_ready_in !== 1'b1 && w < 20);
			xfer_start_out = (i == 0);
			byte_valid_out = 1'b1;
			byte_data_out = d[i];
			@(negedge link_clk_out);
			// released data shows the inverse, not the last byte
			xfer_start_out = 1'b0;
			byte_valid_out = 1'b0;
			byte_data_out = ~d[i];
		end
		// keep clocking until the last handshake closes
		w = 0;
		while (link_ready_in !== 1'b1 && w < 20)
		begin
			@(negedge link_clk_out);
			w++;
		end
		run = 1'b0;
	endtask : write_seq
endmodule : avs_host_model

// file: tb_avs_ctrl.sv
/*
 * tb_avs_ctrl: self-checking bench of the switch control register bank.
 * Assumes avs_pkg and avs_ctrl are compiled first; registers are loaded only
 * through the host model's sequential transfers.
 */
`timescale 1ns/100ps
module tb_avs_ctrl;
	localparam logic [3:0] ID = 4'h5; // arbitrary identity value
	logic clk_sys_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic link_clk, xfer_start, byte_valid, link_ready;
	logic [7:0] byte_data, status;
	// sense and fault inputs, driven on the falling edge
	logic [1:0] aux_sense = 2'h1, tv_sense = 2'h2, gnd_short = 2'h0, ext_drive = 2'h0;
	avs_pkg::avs_fnc_pin_t aux_fnc, tv_function_pin;
	avs_pkg::avs_aux_route_t route;
	avs_pkg::avs_audio_t audio;
	int n_errors = 0;
	int num_checks = 0;
	logic [7:0] r [5]; // register image to send
	logic [1:0] lv; // expected drive level
	// expected aux selections per code, in avs_vid_src_t order
	logic [3:0] comp [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h6, 4'h9, 4'h0};
	logic [3:0] chro [8] = '{4'h0, 4'h0, 4'h0, 4'h4, 4'h1, 4'h7, 4'h8, 4'h0};
	logic [1:0] aud [8] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};

	// system clock, 50 ns
	always #25 clk_sys_in = ~clk_sys_in;

	avs_host_model u_host (.reset_n_in(reset_n_in), .link_clk_out(link_clk), .xfer_start_out(xfer_start),
		.byte_valid_out(byte_valid), .byte_data_out(byte_data), .link_ready_in(link_ready));

	avs_ctrl #(.DEVICE_ID(ID)) u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .link_clk_in(link_clk),
		.xfer_start_in(xfer_start), .byte_valid_in(byte_valid), .byte_data_in(byte_data),
		.link_ready_out(link_ready), .aux_fnc_sense_in(aux_sense), .tv_function_pin_sense_in(tv_sense),
		.fnc_gnd_short_in(gnd_short), .fnc_ext_drive_in(ext_drive), .aux_fnc_out(aux_fnc),
		.tv_function_pin_out(tv_function_pin), .aux_route_out(route), .audio_out(audio), .status_out(status));

	// compare one value, count it, report a difference at once
	task check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// the single place where the run ends
	task end_sim;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	// send registers 0..n-1, then allow the sync stages to settle
	task load(input int n);
		u_host.write_seq(n, r);
		repeat (6) @(negedge clk_sys_in);
	endtask : load

	// main sequence
	initial
	begin
		r = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		repeat (5) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		check(8'(audio.tv_mute), 8'h01);
		check({route.chroma, route.composite}, 8'h00);
		check(8'(audio.stereo_mode), 8'h00);
		check({6'h0, audio.scart_bypass, audio.line_bypass}, 8'h00);
		check(status, {ID, 4'h0});
		// every aux and tv source code, unmuted
		for (int c = 0; c < 8; c++)
		begin
			r[1] = {2'b00, 3'(c), 3'(c)};
			load(2);
			check(8'(route.composite), 8'(comp[c]));
			check(8'(route.chroma), 8'(chro[c]));
			check(8'(route.audio), 8'(aud[c]));
			check(8'(audio.tv_source), (c == 1 || c == 5 || c == 7) ? 8'h01 : 8'h00);
			check(8'(audio.tv_mute), 8'h00);
		end
		// volume, mute, mode, gain and bypass fields, edges of the range included
		for (int i = 0; i < 4; i++)
		begin
			r[0] = {i[1], i[0], 6'(i * 21)};
			r[3] = {2'b00, 2'(i), 2'(3 - i), 2'b00};
			r[4] = {4'h0, i[0], i[1], !i[0], i[1]};
			load(5);
			check(8'(audio.atten_db), 8'(i * 21));
			check(8'(audio.tv_mute), 8'(i[0]));
			check(8'(audio.aux_mute), 8'(i[1]));
			check(8'(audio.stereo_mode), 8'(i));
			check(8'(audio.dac_gain), 8'(3 - i));
			check(8'(audio.vol_gain_6db), 8'(i[1]));
			check(8'(audio.scart_bypass), 8'(i[1]));
			check(8'(audio.line_bypass), 8'(!i[0]));
			check(8'(audio.line_from_tv_scart), 8'(i[0]));
			check(8'(audio.rf_mono_bypass), 8'(i[1]));
		end
		// directions and levels; level code 11 drives the 11 V level
		for (int k = 0; k < 12; k++)
		begin
			r[2] = {4'h0, 2'(k / 4), 2'(k % 4)};
			lv = (k % 4 == 3) ? avs_pkg::AVS_LVL_11V : 2'(k % 4);
			load(3);
			check({6'h0, aux_fnc.oe, tv_function_pin.oe}, (k < 4) ? 8'h03 : (k < 8) ? 8'h02 : 8'h01);
			if (k < 8)
				check(8'(aux_fnc.level), 8'(lv));
			if (k < 4 || k >= 8)
				check(8'(tv_function_pin.level), 8'(lv));
			check(status, {ID, 2'b00, (k < 4) ? 2'h0 : (k < 8) ? 2'h2 : 2'h1});
		end
		// pass-through, aux to tv then tv to aux
		r[2] = 8'h0C;
		load(3);
		check({4'h0, aux_fnc.oe, tv_function_pin.oe, tv_function_pin.level}, 8'h05);
		aux_sense = 2'h0;
		repeat (6) @(negedge clk_sys_in);
		check({4'h0, aux_fnc.oe, tv_function_pin.oe, aux_fnc.level}, 8'h0A);
		// short at 6 V, then external source at 0 V
		r[2] = 8'h01;
		load(3);
		gnd_short = 2'b01;
		repeat (6) @(negedge clk_sys_in);
		check({6'h0, aux_fnc.oe, tv_function_pin.oe}, 8'h01);
		r[2] = 8'h00;
		ext_drive = 2'b10;
		load(3);
		check({6'h0, aux_fnc.oe, tv_function_pin.oe}, 8'h02);
		// a one-byte transfer leaves higher registers as they were
		r[0] = 8'h40;
		load(1);
		check(8'(audio.tv_mute), 8'h01);
		check(8'(route.composite), 8'h00);
		check(8'(audio.stereo_mode), 8'h03);
		// a second reset in mid-run brings back the power-up image
		reset_n_in = 1'b0;
		repeat (8) @(negedge clk_sys_in);
		reset_n_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		check({7'h0, audio.aux_mute}, 8'h01);
		check(8'(audio.tv_mute), 8'h01);
		check(8'(route.composite), 8'h00);
		check(8'(audio.stereo_mode), 8'h00);
		check({6'h0, audio.scart_bypass, audio.line_bypass}, 8'h00);
		end_sim;
	end

	// watchdog, well beyond the expected run of some 70 us
	initial
	begin
		#2000000;
		n_errors++;
		end_sim;
	end
endmodule : tb_avs_ctrl
